// *** flash_cmd_core.sv ***
// serial flash command interpreter: resume, power-down and id reads
`timescale 1ns/100ps
`include "flash_cmd_regs.svh"

// Function
// - resume opcode continues the suspended operation
// - resume accepted only if suspended and idle
// - resume clears suspend now, busy within 200ns
// - suspend lost at power fail ignores resume
// - power-down runs only if cs rises after bit 8
// - power-down entered within entry time after cs
// - powered down, only release opcode is recognised
// - reset always leaves device in normal operation
// - release wakes after wake time, then commands accepted
// - release plus 3 dummies repeats device id byte
// - wake with id read uses shorter wake time
// - release ignored while busy
// - opcode 90h returns manufacturer then device codes
// - opcode 92h dual address and dual id output
// - opcode 94h: dummies, quad address, quad id output
// - four-byte mode lengthens dual/quad address to 32
// - opcode 4Bh plus 4 dummies shifts unique number
// - suspend sets flag now, clears busy within latency
module flash_cmd_core (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic [3:0] io_in,
    input wire logic addr4_mode,
    input wire logic op_start,
    input wire logic op_done,
    input wire logic power_fail,
    output flash_cmd_pkg::io_drive_t io_reg,
    output flash_cmd_pkg::flags_t flags_reg,
    output logic resume_req_reg,
    output logic suspend_req_reg
);

    localparam int RESUME_CYC = `RESUME_BUSY_NS / `CORE_CLK_NS;
    localparam int SUS_CYC = `SUSPEND_LATENCY_NS / `CORE_CLK_NS;
    localparam int PD_CYC = `POWER_DOWN_ENTRY_NS / `CORE_CLK_NS;
    localparam int WAKE_CYC = `WAKE_TIME_NS / `CORE_CLK_NS;
    localparam int WAKE_ID_CYC = `WAKE_WITH_ID_TIME_NS / `CORE_CLK_NS;

    // ****************************************
    // helpers
    // ****************************************

    // link clocks after the opcode before data goes out
    function automatic logic [7:0] phase_clks(input logic [7:0] op, input logic a4);
        logic [7:0] addr_bits;
        addr_bits = a4 ? 8'd32 : 8'd24;
        if (op == `OP_RELEASE_ID)
            return 8'(`RELEASE_DUMMY_CLKS);
        else if (op == `OP_MFR_DEV_ID)
            return 8'(`SINGLE_ADDR_CLKS);
        else if (op == `OP_MFR_DEV_ID_DUAL)
            return 8'((addr_bits + 8'(`MODE_BITS)) >> 1);
        else if (op == `OP_MFR_DEV_ID_QUAD)
            return 8'(`QUAD_LEAD_DUMMY_CLKS) + 8'((addr_bits + 8'(`MODE_BITS)) >> 2);
        else if (op == `OP_UNIQUE_ID)
            return 8'(`UNIQUE_DUMMY_CLKS);
        else
            return 8'd0;
    endfunction

    // whether an opcode is taken in the present device state
    function automatic logic allowed(input logic [7:0] op, input flash_cmd_pkg::flags_t f);
        if (f.waking)
            return 1'b0;
        else if (f.power_down)
            return op == `OP_RELEASE_ID && !f.busy;
        else if (op == `OP_RELEASE_ID)
            return !f.busy;
        else
            return op == `OP_RESUME || op == `OP_SUSPEND || op == `OP_POWER_DOWN
                || op == `OP_MFR_DEV_ID || op == `OP_MFR_DEV_ID_DUAL
                || op == `OP_MFR_DEV_ID_QUAD || op == `OP_UNIQUE_ID;
    endfunction

    // output bits per falling edge
    function automatic logic [2:0] out_width(input logic [7:0] op);
        if (op == `OP_MFR_DEV_ID_DUAL)
            return 3'd2;
        else if (op == `OP_MFR_DEV_ID_QUAD)
            return 3'd4;
        else
            return 3'd1;
    endfunction

    // byte after the current one; id sequences wrap forever
    function automatic logic [3:0] next_idx(input logic [7:0] op, input logic [3:0] idx);
        if (op == `OP_RELEASE_ID)
            return `IDX_DEV;
        else if (op == `OP_UNIQUE_ID)
            return (idx == `IDX_UID_LAST) ? `IDX_UID_FIRST : idx + 4'h1;
        else
            return idx ^ 4'h1;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic sck_s1_reg;
    logic sck_s2_reg;
    logic sck_s3_reg;
    logic cs_n_s1_reg;
    logic cs_n_s2_reg;
    logic cs_n_s3_reg;
    logic [3:0] io_s1_reg;
    logic [3:0] io_s2_reg;

    // two flops before use; third stage only for edge finding
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            cs_n_s1_reg <= 1'b1;
            cs_n_s2_reg <= 1'b1;
            cs_n_s3_reg <= 1'b1;
            io_s1_reg <= 4'h0;
            io_s2_reg <= 4'h0;
        end
        else
        begin
            sck_s1_reg <= sck_pin;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            cs_n_s1_reg <= cs_n_pin;
            cs_n_s2_reg <= cs_n_s1_reg;
            cs_n_s3_reg <= cs_n_s2_reg;
            io_s1_reg <= io_in;
            io_s2_reg <= io_s1_reg;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_low;
    assign sck_rise = sck_s2_reg && !sck_s3_reg;
    assign sck_fall = !sck_s2_reg && sck_s3_reg;
    assign cs_rise = cs_n_s2_reg && !cs_n_s3_reg;
    assign cs_low = !cs_n_s2_reg;

    // ****************************************
    // command sequencer
    // ****************************************
    flash_cmd_pkg::cmd_state_t state_reg;
    logic [7:0] opcode_reg;
    logic [7:0] cmd_reg;
    logic [7:0] plen_reg;
    logic [7:0] cnt_reg;
    logic [7:0] op_full;
    logic op_taken;
    logic enter_out;
    assign op_full = {opcode_reg[6:0], io_s2_reg[0]};
    assign op_taken = sck_rise && cs_low && state_reg == flash_cmd_pkg::ST_OPCODE
        && cnt_reg == 8'(`OPCODE_CLKS - 1);
    assign enter_out = sck_rise && cs_low && state_reg == flash_cmd_pkg::ST_ADDR
        && plen_reg != 8'd0 && cnt_reg + 8'd1 == 8'(`OPCODE_CLKS) + plen_reg;

    // sample on rising link clock, restart on every cs rise
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state_reg <= flash_cmd_pkg::ST_OPCODE;
            opcode_reg <= 8'h00;
            cmd_reg <= 8'h00;
            plen_reg <= 8'd0;
            cnt_reg <= 8'd0;
        end
        else if (cs_rise)
        begin
            state_reg <= flash_cmd_pkg::ST_OPCODE;
            cnt_reg <= 8'd0;
            cmd_reg <= 8'h00;
        end
        else if (sck_rise && cs_low)
        begin
            cnt_reg <= (cnt_reg == 8'hff) ? cnt_reg : cnt_reg + 8'd1;
            case (state_reg)
                flash_cmd_pkg::ST_OPCODE:
                begin
                    opcode_reg <= op_full;
                    if (op_taken && !allowed(op_full, flags_reg))
                        state_reg <= flash_cmd_pkg::ST_IGNORE;
                    else if (op_taken)
                    begin
                        cmd_reg <= op_full;
                        plen_reg <= phase_clks(op_full, addr4_mode);
                        state_reg <= flash_cmd_pkg::ST_ADDR;
                    end
                end
                flash_cmd_pkg::ST_ADDR:
                begin
                    if (enter_out)
                        state_reg <= flash_cmd_pkg::ST_OUT;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ****************************************
    // command execution at cs rise
    // ****************************************
    flash_cmd_pkg::timer_kind_t tmr_kind_reg;
    logic [15:0] tmr_reg;
    logic exec_ok;
    logic tmr_idle;
    logic tmr_expire;
    logic resume_go;
    logic suspend_go;
    logic pd_go;
    logic wake_go;
    logic wake_id;
    // single-byte commands run only when cs rose right after bit 8
    assign exec_ok = cs_rise && state_reg == flash_cmd_pkg::ST_ADDR
        && cnt_reg == 8'(`OPCODE_CLKS);
    assign tmr_idle = tmr_kind_reg == flash_cmd_pkg::T_IDLE;
    assign tmr_expire = !tmr_idle && tmr_reg == 16'd1;
    assign resume_go = exec_ok && cmd_reg == `OP_RESUME && flags_reg.suspend_flag
        && !flags_reg.busy && tmr_idle;
    assign suspend_go = exec_ok && cmd_reg == `OP_SUSPEND && !flags_reg.suspend_flag
        && flags_reg.busy && tmr_idle;
    assign pd_go = exec_ok && cmd_reg == `OP_POWER_DOWN && tmr_idle;
    assign wake_id = state_reg == flash_cmd_pkg::ST_OUT;
    assign wake_go = cs_rise && cmd_reg == `OP_RELEASE_ID && flags_reg.power_down
        && (exec_ok || wake_id) && tmr_idle;

    // one shared timer; a command finding it running is dropped
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            tmr_kind_reg <= flash_cmd_pkg::T_IDLE;
            tmr_reg <= 16'd0;
        end
        else if (resume_go)
        begin
            tmr_kind_reg <= flash_cmd_pkg::T_RESUME;
            tmr_reg <= 16'(RESUME_CYC);
        end
        else if (suspend_go)
        begin
            tmr_kind_reg <= flash_cmd_pkg::T_SUSPEND;
            tmr_reg <= 16'(SUS_CYC);
        end
        else if (pd_go)
        begin
            tmr_kind_reg <= flash_cmd_pkg::T_PD_ENTER;
            tmr_reg <= 16'(PD_CYC);
        end
        else if (wake_go)
        begin
            tmr_kind_reg <= flash_cmd_pkg::T_WAKE;
            tmr_reg <= wake_id ? 16'(WAKE_ID_CYC) : 16'(WAKE_CYC);
        end
        else if (tmr_expire)
            tmr_kind_reg <= flash_cmd_pkg::T_IDLE;
        else if (!tmr_idle)
            tmr_reg <= tmr_reg - 16'd1;
    end

    // ****************************************
    // status flags and array requests
    // ****************************************
    // power fail drops the suspension, so a later resume finds nothing
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            flags_reg <= '0;
            resume_req_reg <= 1'b0;
            suspend_req_reg <= 1'b0;
        end
        else
        begin
            resume_req_reg <= resume_go;
            suspend_req_reg <= suspend_go;
            if (power_fail)
            begin
                flags_reg.suspend_flag <= 1'b0;
                flags_reg.busy <= 1'b0;
            end
            else
            begin
                if (resume_go)
                    flags_reg.suspend_flag <= 1'b0;
                else if (suspend_go)
                    flags_reg.suspend_flag <= 1'b1;
                if (tmr_expire && tmr_kind_reg == flash_cmd_pkg::T_RESUME)
                    flags_reg.busy <= 1'b1;
                else if (op_start)
                    flags_reg.busy <= 1'b1;
                else if (op_done && !flags_reg.suspend_flag)
                    flags_reg.busy <= 1'b0;
                else if (tmr_expire && tmr_kind_reg == flash_cmd_pkg::T_SUSPEND)
                    flags_reg.busy <= 1'b0;
            end
            if (tmr_expire && tmr_kind_reg == flash_cmd_pkg::T_PD_ENTER)
                flags_reg.power_down <= 1'b1;
            else if (tmr_expire && tmr_kind_reg == flash_cmd_pkg::T_WAKE)
                flags_reg.power_down <= 1'b0;
            if (wake_go)
                flags_reg.waking <= 1'b1;
            else if (tmr_expire && tmr_kind_reg == flash_cmd_pkg::T_WAKE)
                flags_reg.waking <= 1'b0;
        end
    end

    // ****************************************
    // id output shifter
    // ****************************************
    logic [3:0] byte_idx_reg;
    logic [2:0] pos_reg;
    logic [2:0] width;
    logic [7:0] rom_data;
    logic [7:0] shifted;
    assign width = out_width(cmd_reg);
    assign shifted = rom_data >> (pos_reg - (width - 3'd1));

    id_rom u_id_rom (
        .core_clk(core_clk),
        .nrst(nrst),
        .addr(byte_idx_reg),
        .rd_data_reg(rom_data)
    );

    // change pads on falling link clock, msb first; release at cs rise
    always_ff @(posedge core_clk)
    begin
        if (!nrst || cs_rise)
        begin
            io_reg <= '0;
            byte_idx_reg <= `IDX_MFR;
            pos_reg <= 3'd7;
        end
        else if (enter_out)
        begin
            pos_reg <= 3'd7;
            if (cmd_reg == `OP_RELEASE_ID)
                byte_idx_reg <= `IDX_DEV;
            else if (cmd_reg == `OP_UNIQUE_ID)
                byte_idx_reg <= `IDX_UID_FIRST;
            else
                byte_idx_reg <= `IDX_MFR;
        end
        else if (sck_fall && cs_low && state_reg == flash_cmd_pkg::ST_OUT)
        begin
            if (width == 3'd4)
            begin
                io_reg.out <= shifted[3:0];
                io_reg.oe <= 4'hf;
            end
            else if (width == 3'd2)
            begin
                io_reg.out <= {2'b00, shifted[1:0]};
                io_reg.oe <= 4'h3;
            end
            else
            begin
                io_reg.out <= {2'b00, shifted[0], 1'b0};
                io_reg.oe <= 4'h2;
            end
            if (pos_reg < width)
            begin
                pos_reg <= 3'd7;
                byte_idx_reg <= next_idx(cmd_reg, byte_idx_reg);
            end
            else
                pos_reg <= pos_reg - width;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    // flag lands the cycle after the timer hits one, hence the extra cycle
    sequence s_pd_lands;
        !flags_reg.power_down ##1 flags_reg.power_down;
    endsequence
    sequence s_resume_taken;
        resume_go && flags_reg.suspend_flag && !flags_reg.busy;
    endsequence
    sequence s_busy_back;
        !flags_reg.suspend_flag ##[1:2] flags_reg.busy;
    endsequence

    property p_resume_flags;
        @(posedge core_clk) disable iff (!nrst)
        s_resume_taken |=> s_busy_back;
    endproperty
    a_resume_flags: assert property (p_resume_flags) else $error("resume flag sequence wrong");

    property p_resume_gate;
        @(posedge core_clk) disable iff (!nrst)
        resume_req_reg |-> $past(flags_reg.suspend_flag) && !$past(flags_reg.busy);
    endproperty
    a_resume_gate: assert property (p_resume_gate) else $error("resume taken in bad state");

    property p_suspend_flags;
        @(posedge core_clk) disable iff (!nrst || power_fail)
        suspend_go |=> flags_reg.suspend_flag ##[0:200] !flags_reg.busy;
    endproperty
    a_suspend_flags: assert property (p_suspend_flags) else $error("suspend latency missed");

    property p_pd_entry;
        @(posedge core_clk) disable iff (!nrst)
        pd_go |-> ##[PD_CYC:PD_CYC] s_pd_lands;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power-down entry timing wrong");

    property p_pd_only_release;
        @(posedge core_clk) disable iff (!nrst)
        op_taken && flags_reg.power_down && op_full != `OP_RELEASE_ID
            |=> state_reg == flash_cmd_pkg::ST_IGNORE;
    endproperty
    a_pd_only_release: assert property (p_pd_only_release) else $error("command taken in power-down");

    property p_reset_normal;
        @(posedge core_clk)
        !nrst |=> !flags_reg.power_down && !flags_reg.waking;
    endproperty
    a_reset_normal: assert property (p_reset_normal) else $error("reset left power-down");

    property p_wake_blocks;
        @(posedge core_clk) disable iff (!nrst)
        wake_go && !wake_id |=> flags_reg.waking [*8] ##22 flags_reg.power_down
            ##1 !flags_reg.power_down;
    endproperty
    a_wake_blocks: assert property (p_wake_blocks) else $error("wake time wrong");

    property p_busy_ignores_release;
        @(posedge core_clk) disable iff (!nrst)
        op_taken && flags_reg.busy && op_full == `OP_RELEASE_ID
            |=> state_reg == flash_cmd_pkg::ST_IGNORE;
    endproperty
    a_busy_ignores_release: assert property (p_busy_ignores_release) else $error("release run while busy");

    property p_cs_discard;
        @(posedge core_clk) disable iff (!nrst)
        cs_rise |=> state_reg == flash_cmd_pkg::ST_OPCODE && io_reg.oe == 4'h0;
    endproperty
    a_cs_discard: assert property (p_cs_discard) else $error("cs rise did not discard");

endmodule // flash_cmd_core

// *** flash_cmd_pkg.sv ***
// types shared by the flash command interpreter
package flash_cmd_pkg;

    // command sequencer states
    typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_OUT, ST_IGNORE} cmd_state_t;

    // purpose of the shared delay timer
    typedef enum logic [2:0] {T_IDLE, T_RESUME, T_SUSPEND, T_PD_ENTER, T_WAKE} timer_kind_t;

    // device status flags
    typedef struct packed {
        logic busy;
        logic suspend_flag;
        logic power_down;
        logic waking;
    } flags_t;

    // io pad drive
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } io_drive_t;

endpackage

// *** flash_cmd_regs.svh ***
// opcodes, timing figures and id store indexes of the flash command interpreter
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// ****************************************
// opcodes
// ****************************************
`define OP_RESUME 8'h7a
`define OP_SUSPEND 8'h75
`define OP_POWER_DOWN 8'hb9
`define OP_RELEASE_ID 8'hab
`define OP_MFR_DEV_ID 8'h90
`define OP_MFR_DEV_ID_DUAL 8'h92
`define OP_MFR_DEV_ID_QUAD 8'h94
`define OP_UNIQUE_ID 8'h4b

// ****************************************
// timing, in ns unless noted
// ****************************************
`define CORE_CLK_NS 100
`define RESUME_BUSY_NS 200
`define SUSPEND_LATENCY_NS 20000
`define POWER_DOWN_ENTRY_NS 3000
`define WAKE_TIME_NS 3000
`define WAKE_WITH_ID_TIME_NS 1800

// ****************************************
// phase lengths in link clocks, byte indexes of the id store
// ****************************************
`define OPCODE_CLKS 8
`define RELEASE_DUMMY_CLKS 24
`define SINGLE_ADDR_CLKS 24
`define UNIQUE_DUMMY_CLKS 32
`define QUAD_LEAD_DUMMY_CLKS 4
`define MODE_BITS 8
`define IDX_MFR 4'h0
`define IDX_DEV 4'h1
`define IDX_UID_FIRST 4'h2
`define IDX_UID_LAST 4'h9

`endif

// *** flash_host_model.sv ***
// host-side serial flash controller model driving the link pins
`timescale 1ns/100ps

// ****************************************
// host link model
// ****************************************
module flash_host_model (
    input wire logic core_clk,
    input flash_cmd_pkg::io_drive_t io_reg,
    output logic cs_n_pin,
    output logic sck_pin,
    output logic [3:0] io_in,
    output logic oe_seen
);
    // idle: deselected, link clock parked low (mode 0)
    initial
    begin
        cs_n_pin = 1'b1;
        sck_pin = 1'b0;
        io_in = 4'h0;
        oe_seen = 1'b0;
    end

    // every change lands just after a core edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // n link clocks of w lanes; reply taken just before the rise
    task automatic xfer(input logic [63:0] v, input int n, input int w, output logic [63:0] r);
        logic [3:0] m;
        logic [3:0] q;
        m = 4'((1 << w) - 1);
        r = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            io_in = 4'(v >> (i * w)) & m;
            wait_clk(4);
            q = (w == 1) ? {3'h0, io_reg.out[1]} : io_reg.out & m;
            oe_seen = oe_seen | (io_reg.oe != 4'h0);
            r = (r << w) | 64'(q);
            sck_pin = 1'b1;
            wait_clk(4);
            sck_pin = 1'b0;
        end
    endtask

    // select; stale bus inverted on release so old data never reads back
    task automatic open_frame();
        wait_clk(1);
        cs_n_pin = 1'b0;
        oe_seen = 1'b0;
    endtask

    task automatic close_frame(input int hold);
        wait_clk(4);
        cs_n_pin = 1'b1;
        io_in = ~io_in;
        wait_clk(hold);
    endtask

    // opcode, payload of n clocks, rn read clocks with a toggling filler
    task automatic command(input logic [7:0] op, input logic [63:0] v, input int n, input int w,
        input int rn, output logic [63:0] r, input int hold);
        logic [63:0] unused;
        open_frame();
        xfer(64'(op), 8, 1, unused);
        if (n > 0)
            xfer(v, n, w, unused);
        r = '0;
        if (rn > 0)
            xfer(64'h5555_5555_5555_5555, rn, w, r);
        close_frame(hold);
    endtask
endmodule // flash_host_model

// *** id_rom.sv ***
// identification byte store with registered read
`timescale 1ns/100ps

module id_rom #(
    parameter logic [7:0] MFR_ID = 8'h5a,               // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h21,               // arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // arbitrary value
)(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    output logic [7:0] rd_data_reg
);

    // registered read so the pad mux sees a stable byte
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            rd_data_reg <= 8'h00;
        else if (addr == `IDX_MFR)
            rd_data_reg <= MFR_ID;
        else if (addr == `IDX_DEV)
            rd_data_reg <= DEV_ID;
        else if (addr >= `IDX_UID_FIRST && addr <= `IDX_UID_LAST)
            rd_data_reg <= UNIQUE_ID[8'(8'd63 - 8'({4'h0, addr - `IDX_UID_FIRST} << 3)) -: 8];
        else
            rd_data_reg <= 8'h00;
    end

endmodule // id_rom

// *** tb.sv ***
// self-checking bench of the flash command interpreter
`timescale 1ns/100ps
`include "flash_cmd_regs.svh"

module tb;
    // arbitrary id values, matching the store defaults
    localparam logic [7:0] MFR = 8'h5a;
    localparam logic [7:0] DEV = 8'h21;
    localparam logic [63:0] UID = 64'h0123_4567_89ab_cdef;
    logic core_clk = 1'b0;
    logic nrst;
    logic addr4_mode;
    logic op_start;
    logic op_done;
    logic power_fail;
    logic cs_n_pin;
    logic sck_pin;
    logic [3:0] io_in;
    logic oe_seen;
    flash_cmd_pkg::io_drive_t io_reg;
    flash_cmd_pkg::flags_t flags_reg;
    logic resume_req_reg;
    logic suspend_req_reg;
    logic [63:0] r;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int resume_cnt = 0;
    int suspend_cnt = 0;
    int w;

    always #50 core_clk = ~core_clk;

    flash_cmd_core i_dut (.core_clk(core_clk), .nrst(nrst), .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin), .io_in(io_in), .addr4_mode(addr4_mode), .op_start(op_start),
        .op_done(op_done), .power_fail(power_fail), .io_reg(io_reg), .flags_reg(flags_reg),
        .resume_req_reg(resume_req_reg), .suspend_req_reg(suspend_req_reg));
    flash_host_model i_host (.core_clk(core_clk), .io_reg(io_reg), .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin), .io_in(io_in), .oe_seen(oe_seen));

    task automatic summarize();
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle array event: 0 start, 1 done, 2 power fail
    task automatic pulse(input int which);
        op_start = (which == 0);
        op_done = (which == 1);
        power_fail = (which == 2);
        i_host.wait_clk(1);
        op_start = 1'b0;
        op_done = 1'b0;
        power_fail = 1'b0;
        i_host.wait_clk(2);
    endtask

    // count resume pulses; the ceiling cuts a hang short
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (resume_req_reg === 1'b1)
            resume_cnt <= resume_cnt + 1;
        if (suspend_req_reg === 1'b1)
            suspend_cnt <= suspend_cnt + 1;
        if (cycles == 40000)
        begin
            bad_count = bad_count + 1;
            summarize();
        end
    end

    initial
    begin
        nrst = 1'b0;
        addr4_mode = 1'b0;
        op_start = 1'b0;
        op_done = 1'b0;
        power_fail = 1'b0;
        i_host.wait_clk(12);
        nrst = 1'b1;
        i_host.wait_clk(3);
        check(64'({flags_reg, io_reg.oe}), 64'h0);
        i_host.command(`OP_MFR_DEV_ID, 64'h0, 24, 1, 32, r, 8);
        check(r, 64'({MFR, DEV, MFR, DEV}));
        // dual and quad, both address widths
        for (int k = 0; k < 4; k++)
        begin
            addr4_mode = k[0];
            w = (k < 2) ? 2 : 4;
            i_host.command((k < 2) ? `OP_MFR_DEV_ID_DUAL : `OP_MFR_DEV_ID_QUAD, 64'hf0,
                (k < 2) ? 16 + 4 * k : 12 + 2 * k[0], w, 32 / w, r, 8);
            check(r, 64'({MFR, DEV, MFR, DEV}));
        end
        addr4_mode = 1'b0;
        i_host.command(`OP_UNIQUE_ID, 64'h0, 32, 1, 64, r, 8);
        check(r, UID);
        i_host.command(`OP_RELEASE_ID, 64'h0, 24, 1, 16, r, 40);
        check(r, 64'({DEV, DEV}));
        // resume refused unless suspended and idle
        i_host.command(`OP_RESUME, 64'h0, 0, 1, 0, r, 8);
        check(64'({flags_reg, 4'(resume_cnt)}), 64'h00);
        pulse(0);
        i_host.command(`OP_RESUME, 64'h0, 0, 1, 0, r, 8);
        check(64'({flags_reg, 4'(resume_cnt)}), 64'h80);
        i_host.command(`OP_RELEASE_ID, 64'h0, 24, 1, 16, r, 8);
        check(64'({flags_reg, oe_seen}), 64'h10);
        i_host.command(`OP_SUSPEND, 64'h0, 0, 1, 0, r, 8);
        check(64'({flags_reg, 4'(suspend_cnt)}), 64'hc1);
        i_host.wait_clk(200);
        check(64'(flags_reg), 64'h4);
        i_host.command(`OP_RESUME, 64'h0, 0, 1, 0, r, 8);
        check(64'({flags_reg, 4'(resume_cnt)}), 64'h81);
        i_host.wait_clk(200);
        i_host.command(`OP_SUSPEND, 64'h0, 0, 1, 0, r, 210);
        pulse(2);
        i_host.command(`OP_RESUME, 64'h0, 0, 1, 0, r, 8);
        check(64'({flags_reg, 4'(resume_cnt), 4'(suspend_cnt)}), 64'h012);
        pulse(0);
        pulse(1);
        // power-down only when select rises after exactly eight bits
        i_host.open_frame();
        i_host.xfer(64'h5c, 7, 1, r);
        i_host.close_frame(40);
        i_host.command(`OP_POWER_DOWN, 64'h1, 1, 1, 0, r, 40);
        check(64'(flags_reg), 64'h0);
        i_host.command(`OP_POWER_DOWN, 64'h0, 0, 1, 0, r, 40);
        check(64'(flags_reg), 64'h2);
        i_host.command(`OP_MFR_DEV_ID, 64'h0, 24, 1, 32, r, 8);
        check(64'({flags_reg, oe_seen}), 64'h4);
        // plain wake, then wake with id: the id wake is shorter
        for (int k = 0; k < 2; k++)
        begin
            if (k == 1)
                i_host.command(`OP_POWER_DOWN, 64'h0, 0, 1, 0, r, 40);
            i_host.command(`OP_RELEASE_ID, 64'h0, 24 * k, 1, 8 * k, r, 12);
            check(64'({flags_reg, r[7:0]}), 64'({4'h3, k ? DEV : 8'h0}));
            i_host.wait_clk(13);
            check(64'(flags_reg), k ? 64'h0 : 64'h3);
            i_host.wait_clk(15);
        end
        i_host.command(`OP_MFR_DEV_ID, 64'h0, 24, 1, 16, r, 8);
        check(r, 64'({MFR, DEV}));
        summarize();
    end
endmodule // tb
